// *** core/sms_pkg.sv ***
package sms_pkg;

    // ============================================================
    // Slave address layout
    // ============================================================
    localparam logic [4:0] ADDR_FIXED_HI = 5'h0b;  // Upper five address bits, 01011.
    localparam logic [6:0] ALERT_ADDR    = 7'h0c;  // Alert response address, 0001 100.
    localparam logic [1:0] SEL_GND_LO    = 2'h0;   // Select pin tied to ground.
    localparam logic [1:0] SEL_VCC_LO    = 2'h1;   // Select pin tied to supply.
    localparam logic [1:0] SEL_FLOAT_LO  = 2'h2;   // Select pin left open.
    localparam logic [1:0] SEL_SETTLE    = 2'h2;   // Clocks before the synced select pin is real.
    localparam int         SLV_ADDR_W    = 7;

    // ============================================================
    // Byte framing
    // ============================================================
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;   // Data bits before the acknowledge slot.
    localparam logic [1:0] MAX_WR_BYTES  = 2'h2;   // Pointer byte plus one data byte.
    localparam logic       DIR_WRITE     = 1'h0;
    localparam logic       DIR_READ      = 1'h1;
    localparam logic       ALERT_LSB     = 1'h0;   // Low bit sent after own address on alert.

    // ============================================================
    // Reset values
    // ============================================================
    localparam logic [7:0] PTR_RESET     = 8'h00;

    // ============================================================
    // Protocol engine states
    // ============================================================
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_ADDR  = 7'h02,
        S_ACK   = 7'h04,
        S_WDATA = 7'h08,
        S_RDATA = 7'h10,
        S_RACK  = 7'h20,
        S_WAIT  = 7'h40
    } sms_state_t;

endpackage

// *** core/sms_sync.sv ***
`timescale 1ns/100ps

// Two flip-flop synchroniser for levels arriving from outside the clock domain.
module sms_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sms_sync_st_t;

    sms_sync_st_t st_q;
    sms_sync_st_t st_d;

    // ============================================================
    // Stage chain
    // ============================================================
    // The first stage feeds only the second stage.
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // Both stages reset high, matching an idle pulled-up line.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule

// *** core/sms_strap.sv ***
`timescale 1ns/100ps

// Captures the three-state select pin once after reset release and forms the address.
module sms_strap (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sense_up,
    input  wire logic       sense_dn,
    output logic      [6:0] own_addr,
    output logic            addr_valid
);

    typedef struct packed {
        logic       done;
        logic [1:0] settle;
        logic [1:0] lo;
    } sms_strap_st_t;

    sms_strap_st_t st_q;
    sms_strap_st_t st_d;

    // ============================================================
    // One-time capture
    // ============================================================
    // Pulled up and down senses together tell ground, supply and open apart.
    // The synchroniser leaves reset showing ones, so the capture waits until
    // the pin level itself has passed both of its stages.
    always_comb begin
        st_d = st_q;
        if (!st_q.done) begin
            if (st_q.settle != sms_pkg::SEL_SETTLE) begin
                st_d.settle = st_q.settle + 2'h1;
            end else begin
                st_d.done = 1'b1;
                if (sense_up && !sense_dn) begin
                    st_d.lo = sms_pkg::SEL_FLOAT_LO;
                end else if (sense_up) begin
                    st_d.lo = sms_pkg::SEL_VCC_LO;
                end else begin
                    st_d.lo = sms_pkg::SEL_GND_LO;
                end
            end
        end
    end

    // After the capture the pair is frozen until the next power-up reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign own_addr   = {sms_pkg::ADDR_FIXED_HI, st_q.lo};
    assign addr_valid = st_q.done;

    // ============================================================
    // Checks
    // ============================================================
    property p_addr_frozen;
        @(posedge clk) disable iff (!resetn)
        st_q.done |=> $stable(st_q.lo) && st_q.done;
    endproperty
    a_addr_frozen: assert property (p_addr_frozen)
        else $error("Address low bits changed after capture.");

    property p_float_addr;
        @(posedge clk) disable iff (!resetn)
        !st_q.done && st_q.settle == sms_pkg::SEL_SETTLE && sense_up && !sense_dn
        |=> own_addr == 7'h2e;
    endproperty
    a_float_addr: assert property (p_float_addr)
        else $error("Open select pin did not give address 0101110.");

endmodule

// *** core/sms_slave.sv ***
`timescale 1ns/100ps

// How it works
// - Address is 01011 plus two select bits.
// - Select pin captured once after power-up.
// - Open pin gives 0101110; three distinct pairs.
// - Shift in address and direction, MSB first.
// - Acknowledge own address; otherwise stay idle.
// - Direction zero writes, one reads.
// - Nine clocks per byte, acknowledge last.
// - Drive data changes only while clock low.
// - Direction fixed until a new START.
// - Writes of one or two bytes; reads other than the alert answer go on while the master acknowledges.
// - First written byte loads the pointer.
// - Second written byte stores at the pointer.
// - Read returns register selected by pointer.
// - Pointer write, repeated start, read byte.
// - Interrupt is open-drain, shareable as alert.
// - Answer alert address with own address.
// - Lowest address wins alert arbitration.
// - Release interrupt after alert answer; rearm later.
module sms_slave (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       sel_sense_up,
    input  wire logic       sel_sense_dn,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       int_cond,
    input  wire logic       monitor_tick,
    output logic            int_out,
    output logic            int_oe
);

    typedef struct packed {
        sms_pkg::sms_state_t state;
        logic [3:0]          bitcnt;
        logic [7:0]          shreg;
        logic                rw;
        logic                alert;
        logic                macked;
        logic [1:0]          wr_bytes;
        logic [7:0]          ptr;
        logic [7:0]          wdata;
        logic                we;
        logic                sda_oe;
        logic                int_act;
        logic                scl_p;
        logic                sda_p;
        logic                low;
    } sms_slave_st_t;

    sms_slave_st_t st_q;
    sms_slave_st_t st_d;

    logic [1:0] bus_s;
    logic [1:0] sel_s;
    logic       scl_s;
    logic       sda_s;
    logic [6:0] own_addr;
    logic       addr_valid;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       own_hit;
    logic       alert_hit;
    logic       arb_lost;
    logic       alert_done;

    // ============================================================
    // Pin synchronisers and address strap
    // ============================================================
    sms_sync #(
        .W (2)
    ) u_bus_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({scl_in, sda_in}),
        .dout   (bus_s)
    );

    sms_sync #(
        .W (2)
    ) u_sel_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({sel_sense_up, sel_sense_dn}),
        .dout   (sel_s)
    );

    sms_strap u_strap (
        .clk        (clk),
        .resetn     (resetn),
        .sense_up   (sel_s[1]),
        .sense_dn   (sel_s[0]),
        .own_addr   (own_addr),
        .addr_valid (addr_valid)
    );

    // ============================================================
    // Bus event decode
    // ============================================================
    // Edges and conditions come from the synchronised lines and their last values.
    assign scl_s     = bus_s[1];
    assign sda_s     = bus_s[0];
    assign scl_rise  = scl_s && !st_q.scl_p;
    assign scl_fall  = !scl_s && st_q.scl_p;
    assign bus_start = scl_s && st_q.scl_p && st_q.sda_p && !sda_s;
    assign bus_stop  = scl_s && st_q.scl_p && !st_q.sda_p && sda_s;
    assign own_hit   = addr_valid && (st_q.shreg[7:1] == own_addr);
    assign alert_hit = (st_q.shreg[7:1] == sms_pkg::ALERT_ADDR)
                       && (st_q.shreg[0] == sms_pkg::DIR_READ)
                       && st_q.int_act && addr_valid;
    // A released one that reads back low means another sender drives a zero.
    assign arb_lost  = (st_q.state == sms_pkg::S_RDATA) && scl_rise
                       && !st_q.sda_oe && !sda_s;
    assign alert_done = (st_q.state == sms_pkg::S_RDATA) && scl_fall && st_q.alert
                        && (st_q.bitcnt == sms_pkg::BITS_PER_BYTE);

    // ============================================================
    // Protocol engine
    // ============================================================
    // START and STOP override every state; bits move on clock edges.
    always_comb begin
        st_d       = st_q;
        st_d.scl_p = scl_s;
        st_d.sda_p = sda_s;
        st_d.we    = 1'b0;
        st_d.low   = 1'b0;
        if (bus_start) begin
            st_d.state  = sms_pkg::S_ADDR;
            st_d.bitcnt = 4'h0;
            st_d.sda_oe = 1'b0;
            st_d.alert  = 1'b0;
            st_d.wr_bytes = 2'h0;
        end else if (bus_stop) begin
            st_d.state  = sms_pkg::S_IDLE;
            st_d.sda_oe = 1'b0;
        end else begin
            case (st_q.state)
                sms_pkg::S_ADDR, sms_pkg::S_WDATA: begin
                    if (scl_rise && st_q.bitcnt < sms_pkg::BITS_PER_BYTE) begin
                        st_d.shreg  = {st_q.shreg[6:0], sda_s};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall && st_q.bitcnt == sms_pkg::BITS_PER_BYTE) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.state == sms_pkg::S_ADDR) begin
                            if (own_hit || alert_hit) begin
                                st_d.sda_oe = 1'b1;
                                st_d.rw     = st_q.shreg[0];
                                st_d.alert  = alert_hit && !own_hit;
                                st_d.state  = sms_pkg::S_ACK;
                            end else begin
                                st_d.state  = sms_pkg::S_WAIT;
                            end
                        end else if (st_q.wr_bytes < sms_pkg::MAX_WR_BYTES) begin
                            st_d.sda_oe   = 1'b1;
                            st_d.state    = sms_pkg::S_ACK;
                            st_d.wr_bytes = st_q.wr_bytes + 2'h1;
                            if (st_q.wr_bytes == 2'h0) begin
                                st_d.ptr = st_q.shreg;
                            end else begin
                                st_d.wdata = st_q.shreg;
                                st_d.we    = 1'b1;
                            end
                        end else begin
                            st_d.state = sms_pkg::S_WAIT;
                        end
                    end
                end
                sms_pkg::S_ACK: begin
                    // The acknowledge is held across the whole ninth clock.
                    if (scl_fall) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.rw == sms_pkg::DIR_WRITE) begin
                            st_d.sda_oe = 1'b0;
                            st_d.state  = sms_pkg::S_WDATA;
                        end else begin
                            st_d.shreg  = st_q.alert ? {own_addr, sms_pkg::ALERT_LSB}
                                                     : reg_rdata;
                            st_d.sda_oe = st_q.alert ? !own_addr[6] : !reg_rdata[7];
                            st_d.state  = sms_pkg::S_RDATA;
                        end
                    end
                end
                sms_pkg::S_RDATA: begin
                    if (arb_lost) begin
                        st_d.state  = sms_pkg::S_WAIT;
                        st_d.sda_oe = 1'b0;
                    end else if (scl_rise) begin
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_q.bitcnt == sms_pkg::BITS_PER_BYTE) begin
                            st_d.sda_oe = 1'b0;
                            st_d.state  = sms_pkg::S_RACK;
                        end else begin
                            st_d.shreg  = {st_q.shreg[6:0], 1'b0};
                            st_d.sda_oe = !st_q.shreg[6];
                        end
                    end
                end
                sms_pkg::S_RACK: begin
                    // A master acknowledge repeats the selected register.
                    if (scl_rise) begin
                        st_d.macked = !sda_s;
                    end else if (scl_fall) begin
                        if (st_q.macked && !st_q.alert) begin
                            st_d.shreg  = reg_rdata;
                            st_d.sda_oe = !reg_rdata[7];
                            st_d.bitcnt = 4'h0;
                            st_d.state  = sms_pkg::S_RDATA;
                        end else begin
                            st_d.state  = sms_pkg::S_WAIT;
                        end
                    end
                end
                sms_pkg::S_IDLE, sms_pkg::S_WAIT: begin
                    st_d.sda_oe = 1'b0;
                end
                default: begin
                    st_d.state  = sms_pkg::S_IDLE;
                    st_d.sda_oe = 1'b0;
                end
            endcase
        end
        // The monitoring cycle sets the alert and wins over a same-cycle release.
        if (monitor_tick && int_cond) begin
            st_d.int_act = 1'b1;
        end else if (alert_done) begin
            st_d.int_act = 1'b0;
        end
    end

    // State register; every output of the block comes from here.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= '0;
            st_q.state <= sms_pkg::S_IDLE;
            st_q.ptr   <= sms_pkg::PTR_RESET;
            st_q.scl_p <= 1'b1;
            st_q.sda_p <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain pins drive only low; the enables carry the level.
    assign sda_out   = st_q.low;
    assign sda_oe    = st_q.sda_oe;
    assign int_out   = st_q.low;
    assign int_oe    = st_q.int_act;
    assign reg_addr  = st_q.ptr;
    assign reg_wdata = st_q.wdata;
    assign reg_we    = st_q.we;

    // ============================================================
    // Checks
    // ============================================================
    property p_addr_hi;
        @(posedge clk) disable iff (!resetn)
        addr_valid |-> own_addr[6:2] == 5'h0b;
    endproperty
    a_addr_hi: assert property (p_addr_hi)
        else $error("Fixed address bits are wrong.");

    property p_ack_cause;
        @(posedge clk) disable iff (!resetn)
        $rose(st_q.sda_oe) && $past(st_q.state == sms_pkg::S_ADDR)
        |-> $past(own_hit || alert_hit);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("Address acknowledged without a match.");

    property p_ack_hold;
        @(posedge clk) disable iff (!resetn)
        st_q.state == sms_pkg::S_ACK && !scl_fall && !bus_start && !bus_stop
        |=> st_q.sda_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("Acknowledge dropped before the ninth clock ended.");

    property p_drive_clk_low;
        @(posedge clk) disable iff (!resetn)
        $rose(st_q.sda_oe) |-> !$past(scl_s);
    endproperty
    a_drive_clk_low: assert property (p_drive_clk_low)
        else $error("Data line pulled low while clock high.");

    property p_we_second;
        @(posedge clk) disable iff (!resetn)
        st_q.we |-> st_q.wr_bytes == 2'h2 && st_q.wdata == $past(st_q.shreg) ##1 !st_q.we;
    endproperty
    a_we_second: assert property (p_we_second)
        else $error("Register write not from a single second byte.");

    property p_ptr_first;
        @(posedge clk) disable iff (!resetn)
        $changed(st_q.ptr) |-> st_q.wr_bytes == 2'h1 && !st_q.we;
    endproperty
    a_ptr_first: assert property (p_ptr_first)
        else $error("Pointer changed by something other than the first byte.");

    property p_arb_backoff;
        @(posedge clk) disable iff (!resetn)
        arb_lost && !(monitor_tick && int_cond)
        |=> st_q.state == sms_pkg::S_WAIT && !st_q.sda_oe && st_q.int_act;
    endproperty
    a_arb_backoff: assert property (p_arb_backoff)
        else $error("Loser of arbitration kept driving or dropped interrupt.");

    property p_int_release;
        @(posedge clk) disable iff (!resetn)
        $fell(st_q.int_act) |-> $past(alert_done) && $past(st_q.alert);
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("Interrupt released without an alert answer.");

    property p_idle_quiet;
        @(posedge clk) disable iff (!resetn)
        st_q.state == sms_pkg::S_WAIT || st_q.state == sms_pkg::S_IDLE |-> !st_q.sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Data line driven while not selected.");

endmodule

// *** dv/sms_bus_master.sv ***
`timescale 1ns/100ps

// ============================================================
// Bus master model
// ============================================================
// Makes the link clock only inside frames; data moves two clocks after the clock falls.
module sms_bus_master (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            oe,
    output logic      [7:0] rd_byte,
    output logic            rd_tgl
);
    // The bus starts idle with both lines released.
    initial begin
        scl = 1'b1;
        oe = 1'b0;
        rd_byte = 8'h00;
        rd_tgl = 1'b0;
    end

    // Waits n falling edges; eight of them make half a link clock period.
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Opens a frame; from clock low it first parks data high, giving a repeated start.
    task automatic start();
        if (!scl) begin
            wt(2);
            oe = 1'b0;
            wt(6);
            scl = 1'b1;
            wt(8);
        end
        oe = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask

    // Closes a frame: data low under clock low, released while the clock is high.
    task automatic stop();
        wt(2);
        oe = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(8);
        oe = 1'b0;
        wt(8);
    endtask

    // One clock pulse; data changes only while the clock is low and is read late in high.
    task automatic bit_io(input logic v, output logic r);
        wt(2);
        oe = ~v;
        wt(6);
        scl = 1'b1;
        wt(8);
        r = sda;
        scl = 1'b0;
    endtask

    // Sends a byte MSB first and returns the level of the ninth pulse.
    task automatic put(input logic [7:0] b, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, ack_n);
    endtask

    // Reads a byte; zeros in rv act as a rival sender on the wired line.
    task automatic get(input logic [7:0] rv, input logic ack);
        logic       r;
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(rv[i], r);
            b[i] = r;
        end
        bit_io(~ack, r);
        rd_byte = b;
        rd_tgl = ~rd_tgl;
    endtask
endmodule

// *** dv/tb_sms_slave.sv ***
`timescale 1ns/100ps

// ============================================================
// Testbench for the bus slave front end
// ============================================================
module tb_sms_slave;
    localparam int limit_ns = 500000;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sel_up = 1'b0;
    logic        sel_dn = 1'b0;
    logic        int_cond = 1'b0;
    logic        tick = 1'b0;
    logic        sda_out, sda_oe, reg_we, int_out, int_oe, scl, m_oe, rd_tgl, ak, scl_q, oe_q;
    logic  [7:0] reg_addr, reg_wdata, rd_byte, p, d, q;
    logic  [7:0] regs [256];
    logic  [6:0] a;
    logic  [6:0] own [3] = '{7'h2c, 7'h2d, 7'h2e};
    logic [15:0] wq [$];
    logic  [7:0] rq [$];
    int          err_count = 0;
    int          num_checks = 0;
    wire         sda = ~(sda_oe | m_oe);
    wire   [7:0] reg_rdata = regs[reg_addr];

    // The system clock runs at 100 MHz.
    always #5 clk = ~clk;

    sms_slave uut (
        .clk          (clk),
        .resetn       (resetn),
        .scl_in       (scl),
        .sda_in       (sda),
        .sda_out      (sda_out),
        .sda_oe       (sda_oe),
        .sel_sense_up (sel_up),
        .sel_sense_dn (sel_dn),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_we       (reg_we),
        .reg_rdata    (reg_rdata),
        .int_cond     (int_cond),
        .monitor_tick (tick),
        .int_out      (int_out),
        .int_oe       (int_oe)
    );
    sms_bus_master m (.clk(clk), .sda(sda), .scl(scl), .oe(m_oe), .rd_byte(rd_byte),
        .rd_tgl(rd_tgl));

    // Counts one comparison and reports it at once when it fails.
    task automatic note(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g, input string w);
        note(g === e, $sformatf("%s exp %b got %b", w, e, g));
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        note(g === e, $sformatf("read byte exp %h got %h", e, g));
    endtask
    task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
        note(g === e, $sformatf("register write exp %h got %h", e, g));
    endtask

    // Register writes are matched to the oldest note and stored in the local register copy.
    always @(negedge clk) begin
        if (reg_we === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
            chk_reg(wq.size() > 0 ? wq.pop_front() : 16'hxxxx, {reg_addr, reg_wdata});
        end
    end
    // The slave must not move its data drive while the link clock stays high.
    always @(posedge clk) begin
        if (scl_q && scl && sda_oe !== oe_q) note(1'b0, "data moved under high clock");
        scl_q <= scl;
        oe_q <= sda_oe;
    end
    // Every byte the master reads is matched to the oldest read note.
    always @(rd_tgl) begin
        if (resetn === 1'b1) chk_byte(rq.size() > 0 ? rq.pop_front() : 8'hxx, rd_byte);
    end

    // Power-up with a strap setting, then scrambles the strap pins.
    task automatic power_up(input int s);
        resetn = 1'b0;
        sel_up = (s != 0);
        sel_dn = (s == 1);
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        sel_up = 1'($urandom);
        sel_dn = 1'($urandom);
        a = own[s];
    endtask
    // Sends one byte and compares the acknowledge level with the expected one.
    task automatic tx(input logic [7:0] b, input logic e);
        m.put(b, ak);
        chk_bit(e, ak, "acknowledge");
    endtask
    // One monitoring cycle with the given interrupt condition.
    task automatic pulse(input logic c);
        int_cond = c;
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // Alert read; rv models a rival device with a lower address.
    task automatic alert(input logic [7:0] rv, input logic [7:0] e);
        rq.push_back(e);
        m.start();
        tx({7'h0c, 1'b1}, 1'b0);
        m.get(rv, 1'b0);
        m.stop();
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hang is cut short well after the expected run length.
    initial begin
        #(limit_ns);
        note(1'b0, "watchdog expired");
        print_verdict();
    end

    // Main sequence: every strap setting, then the alert flow.
    initial begin
        void'($urandom(32'he40a));
        for (int i = 0; i < 256; i++) regs[i] = 8'($urandom);
        @(negedge clk);
        for (int s = 0; s < 3; s++) begin
            power_up(s);
            chk_bit(1'b0, int_oe, "interrupt idle");
            chk_bit(1'b0, sda_out | int_out, "open-drain drive level");
            p = 8'($urandom);
            d = 8'($urandom);
            q = p ^ 8'h5a;
            m.start();
            tx({own[(s + 1) % 3], 1'b0}, 1'b1);
            m.stop();
            wq.push_back({p, d});
            m.start();
            tx({a, 1'b0}, 1'b0);
            tx(p, 1'b0);
            tx(d, 1'b0);
            tx(~d, 1'b1);
            m.stop();
            rq.push_back(d);
            rq.push_back(d);
            m.start();
            tx({a, 1'b0}, 1'b0);
            tx(p, 1'b0);
            m.start();
            tx({a, 1'b1}, 1'b0);
            m.get(8'hff, 1'b1);
            m.get(8'hff, 1'b0);
            m.stop();
            m.start();
            tx({a, 1'b0}, 1'b0);
            tx(q, 1'b0);
            m.stop();
            rq.push_back(regs[q]);
            m.start();
            tx({a, 1'b1}, 1'b0);
            m.get(8'hff, 1'b0);
            m.stop();
            $display("test strap %0d done", s);
        end
        pulse(1'b1);
        chk_bit(1'b1, int_oe, "interrupt raised");
        m.start();
        tx({7'h0c, 1'b0}, 1'b1);
        m.stop();
        alert(8'h58, 8'h58);
        chk_bit(1'b1, int_oe, "interrupt kept after lost arbitration");
        alert(8'hff, {a, 1'b0});
        chk_bit(1'b0, int_oe, "interrupt released");
        pulse(1'b1);
        chk_bit(1'b1, int_oe, "interrupt rearmed");
        int_cond = 1'b0;
        alert(8'hff, {a, 1'b0});
        pulse(1'b0);
        chk_bit(1'b0, int_oe, "interrupt stays clear");
        m.start();
        tx({7'h0c, 1'b1}, 1'b1);
        m.stop();
        $display("test alert done");
        note(wq.size() == 0 && rq.size() == 0, "expected results never appeared");
        print_verdict();
    end
endmodule
